// >>> verilog/ica_pkg.sv
// How it works
// [RULE1] range tables for destination and source MAC are scanned upward from entry 0
// [RULE2] a matching range entry fires its drop, host redirect and queue actions
// [RULE3] any matching range entry with drop set drops the packet
// [RULE4] any matching redirect sends to the host and beats drop
// [RULE5] among matches forcing a queue, the highest entry index supplies it
// [RULE6] a source address hit with the discard flag always drops
// [RULE7] destination bits 47:8 equal to base index the reserved multicast table by 7:0
// [RULE8] reserved multicast action is per source port: drop or host redirect; the code picks it per address byte 7:0 and only gates it per port
// [RULE9] each engine searches d-left hash ways plus a masked TCAM
// [RULE10] each engine applies one shared mask to all its hash entries
// [RULE11] four engines look up in parallel and their actions merge
// [RULE12] per-port engine enables, all cleared by reset
// [RULE13] an enabled engine uses the port rule index to pick a field bitmap
// [RULE14] a field enters the key exactly when its bitmap bit is set; the code keeps only the first six set bits, counted from bit 0
// [RULE15] engine 0 keys hold up to six fields in 222 bits
// [RULE16] engine 0 pre-lookup picks the rule index, else the port index is used
// [RULE17] pre-lookup key: 3 port bits, vlan count, avtp flag, l3 and l4 types
// [RULE18] l3 type: 0 ipv4, 1 ipv6, 2 mpls, 3 other
// [RULE19] l4 type codes 0 unknown up to 7 mld
// [RULE20] engine 0 field set covers addresses, vlan fields, tag types, ethertype
// [RULE21] l4 port fields are valid only for ipv4 or ipv6 carrying udp or tcp
// [RULE22] selected fields pack above per-field valid bits, upper bits zero
// [RULE23] merged redirect beats merged drop across all engines
package ica_pkg;
  localparam int PORT_N = 64;
  localparam int PORT_W = 6;
  localparam int ENG_N = 4;
  localparam int KEY_W = 222;
  localparam int FLD_N = 19;
  localparam int FLD_MAX = 6;
  localparam int RULE_N = 16;
  localparam int RULE_W = 4;
  localparam int RANGE_N = 8;
  localparam int WAY_N = 4;
  localparam int HDEP = 4;
  localparam int HIDX_W = 2;
  localparam int TCAM_N = 4;
  localparam int PRE_N = 8;
  localparam int PRE_W = 11;
  localparam int PBITS_W = 3;
  localparam int QUEUE_W = 3;
  localparam int MAC_W = 48;
  localparam int RMC_N = 256;
  localparam int RMC_BASE_W = 40;
  // reset value of the per-port engine enables
  localparam logic [3:0] ACL_EN_RST = 4'h0;
  // l3 and l4 type codes
  localparam logic [1:0] L3_IPV4 = 2'h0;
  localparam logic [1:0] L3_IPV6 = 2'h1;
  localparam logic [1:0] L3_MPLS = 2'h2;
  localparam logic [1:0] L3_OTHER = 2'h3;
  localparam logic [2:0] L4_UNKNOWN = 3'h0;
  localparam logic [2:0] L4_OTHER_IP = 3'h1;
  localparam logic [2:0] L4_UDP = 3'h2;
  localparam logic [2:0] L4_TCP = 3'h3;
  localparam logic [2:0] L4_IGMP = 3'h4;
  localparam logic [2:0] L4_ICMP = 3'h5;
  localparam logic [2:0] L4_ICMP6 = 3'h6;
  localparam logic [2:0] L4_MLD = 3'h7;
  // ip protocol numbers and mld message types
  localparam logic [7:0] PROTO_ICMP = 8'h01;
  localparam logic [7:0] PROTO_IGMP = 8'h02;
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [7:0] PROTO_UDP = 8'h11;
  localparam logic [7:0] PROTO_ICMP6 = 8'h3A;
  localparam logic [7:0] MLD_FIRST = 8'h82;
  localparam logic [7:0] MLD_LAST = 8'h84;
  // field positions in the engine 0 bitmap
  localparam int F_MAC_DA = 0;
  localparam int F_MAC_SA = 1;
  localparam int F_OUT_VID = 2;
  localparam int F_HAS_VLAN = 3;
  localparam int F_OUT_TT = 4;
  localparam int F_IN_TT = 5;
  localparam int F_OUT_PCP = 6;
  localparam int F_OUT_DEI = 7;
  localparam int F_IN_VID = 8;
  localparam int F_IN_PCP = 9;
  localparam int F_IN_DEI = 10;
  localparam int F_L4_SPORT = 11;
  localparam int F_L4_DPORT = 12;
  localparam int F_L4_PROTO = 13;
  localparam int F_ETYPE = 14;
  localparam int F_L4_TYPE = 15;
  localparam int F_L3_TYPE = 16;
  localparam int F_SRC_PORT = 17;
  localparam int F_RULE_PTR = 18;
  localparam int FLD_W [FLD_N] = '{48, 48, 12, 1, 1, 1, 3, 1, 12, 3, 1,
                                   16, 16, 8, 16, 3, 2, 6, 4};

  typedef struct packed {
    logic [47:0] mac_da;
    logic [47:0] mac_sa;
    logic [11:0] outer_vid;
    logic [11:0] inner_vid;
    logic [2:0] outer_pcp;
    logic [2:0] inner_pcp;
    logic outer_dei;
    logic inner_dei;
    logic outer_svlan;
    logic inner_svlan;
    logic [1:0] vlan_cnt;
    logic avtp;
    logic is_ipv4;
    logic is_ipv6;
    logic is_mpls;
    logic [7:0] l4_proto;
    logic [7:0] icmp6_type;
    logic [15:0] l4_sport;
    logic [15:0] l4_dport;
    logic [15:0] ethertype;
    logic [5:0] src_port;
    logic source_addr_discard;
  } ica_hdr_s;

  typedef struct packed {
    logic drop;
    logic redirect_to_host;
    logic egress_queue_override;
    logic [2:0] queue;
  } ica_act_s;

  typedef struct packed {
    logic en;
    logic [47:0] lo;
    logic [47:0] hi;
    ica_act_s act;
  } ica_range_s;

  typedef struct packed {
    logic valid;
    logic [10:0] key;
    logic [10:0] mask;
    logic [3:0] rule;
  } ica_pre_s;

  typedef struct packed {
    logic en;
    logic [5:0] port;
    logic [3:0] acl_port_enable;
    logic [3:0][3:0] acl_rule_index;
    logic [2:0] prelookup_port_bits;
  } ica_port_cfg_s;

  typedef struct packed {
    logic en;
    logic [1:0] eng;
    logic tcam;
    logic [1:0] way;
    logic [1:0] idx;
    logic valid;
    logic [221:0] key;
    logic [221:0] mask;
    ica_act_s act;
  } ica_acl_wr_s;
endpackage

// >>> verilog/ica_classifier.sv
`timescale 1ns/1ns
module ica_classifier (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // parsed header from the ingress parser
  input wire logic hdr_valid_i,
  input wire ica_pkg::ica_hdr_s hdr_i,
  // mac range tables
  input wire ica_pkg::ica_range_s da_range_i [ica_pkg::RANGE_N],
  input wire ica_pkg::ica_range_s sa_range_i [ica_pkg::RANGE_N],
  // reserved multicast
  input wire logic [39:0] rmc_base_i,
  input wire logic [255:0] rmc_drop_i,
  input wire logic [255:0] rmc_redirect_i,
  input wire logic [63:0] rmc_port_en_i,
  // acl configuration
  input wire ica_pkg::ica_port_cfg_s port_cfg_i,
  input wire ica_pkg::ica_acl_wr_s acl_wr_i,
  input wire logic [18:0] key_field_bitmap_i [ica_pkg::ENG_N][ica_pkg::RULE_N],
  input wire logic [221:0] hash_mask_i [ica_pkg::ENG_N],
  input wire ica_pkg::ica_pre_s pre_tbl_i [ica_pkg::PRE_N],
  // classification result
  output logic res_valid_o,
  output ica_pkg::ica_act_s res_o,
  output logic [3:0] acl_hit_o,
  output logic [3:0] rule_ptr0_o
);

  // merge one action into an accumulator; later sources win the queue
  function automatic ica_pkg::ica_act_s merge(ica_pkg::ica_act_s acc,
                                              ica_pkg::ica_act_s a);
    ica_pkg::ica_act_s r;
    r = acc;
    r.drop = acc.drop | a.drop;
    r.redirect_to_host = acc.redirect_to_host | a.redirect_to_host;
    if (a.egress_queue_override) begin
      r.egress_queue_override = 1'b1;
      r.queue = a.queue;
    end
    return r;
  endfunction

  function automatic logic rhit(ica_pkg::ica_range_s e, logic [47:0] mac);
    return e.en && (mac >= e.lo) && (mac <= e.hi);
  endfunction

  function automatic logic is_ip(ica_pkg::ica_hdr_s h);
    return h.is_ipv4 | h.is_ipv6;
  endfunction

  function automatic logic [1:0] l3_code(ica_pkg::ica_hdr_s h);
    logic [1:0] c;
    c = ica_pkg::L3_OTHER;
    if (h.is_ipv4) begin
      c = ica_pkg::L3_IPV4; // RULE18
    end else if (h.is_ipv6) begin
      c = ica_pkg::L3_IPV6;
    end else if (h.is_mpls) begin
      c = ica_pkg::L3_MPLS;
    end
    return c;
  endfunction

  function automatic logic [2:0] l4_code(ica_pkg::ica_hdr_s h);
    logic [2:0] c;
    c = ica_pkg::L4_UNKNOWN;
    if (is_ip(h)) begin
      c = ica_pkg::L4_OTHER_IP; // RULE19
      if (h.l4_proto == ica_pkg::PROTO_UDP) begin
        c = ica_pkg::L4_UDP;
      end else if (h.l4_proto == ica_pkg::PROTO_TCP) begin
        c = ica_pkg::L4_TCP;
      end else if (h.l4_proto == ica_pkg::PROTO_IGMP) begin
        c = ica_pkg::L4_IGMP;
      end else if (h.l4_proto == ica_pkg::PROTO_ICMP && h.is_ipv4) begin
        c = ica_pkg::L4_ICMP;
      end else if (h.l4_proto == ica_pkg::PROTO_ICMP6 && h.is_ipv6) begin
        // mld is a sub protocol of icmpv6 and is reported apart from it
        if (h.icmp6_type >= ica_pkg::MLD_FIRST && h.icmp6_type <= ica_pkg::MLD_LAST) begin
          c = ica_pkg::L4_MLD;
        end else begin
          c = ica_pkg::L4_ICMP6;
        end
      end
    end
    return c;
  endfunction

  // raw value of one selectable field, zero extended
  function automatic logic [47:0] fld(ica_pkg::ica_hdr_s h, int i, logic [3:0] rp);
    logic [47:0] v;
    v = '0;
    case (i) // RULE20
      ica_pkg::F_MAC_DA: v = h.mac_da;
      ica_pkg::F_MAC_SA: v = h.mac_sa;
      ica_pkg::F_OUT_VID: v[11:0] = h.outer_vid;
      ica_pkg::F_HAS_VLAN: v[0] = (h.vlan_cnt != 2'h0);
      ica_pkg::F_OUT_TT: v[0] = h.outer_svlan;
      ica_pkg::F_IN_TT: v[0] = h.inner_svlan;
      ica_pkg::F_OUT_PCP: v[2:0] = h.outer_pcp;
      ica_pkg::F_OUT_DEI: v[0] = h.outer_dei;
      ica_pkg::F_IN_VID: v[11:0] = h.inner_vid;
      ica_pkg::F_IN_PCP: v[2:0] = h.inner_pcp;
      ica_pkg::F_IN_DEI: v[0] = h.inner_dei;
      ica_pkg::F_L4_SPORT: v[15:0] = h.l4_sport;
      ica_pkg::F_L4_DPORT: v[15:0] = h.l4_dport;
      ica_pkg::F_L4_PROTO: v[7:0] = h.l4_proto;
      ica_pkg::F_ETYPE: v[15:0] = h.ethertype;
      ica_pkg::F_L4_TYPE: v[2:0] = l4_code(h);
      ica_pkg::F_L3_TYPE: v[1:0] = l3_code(h);
      ica_pkg::F_SRC_PORT: v[5:0] = h.src_port;
      ica_pkg::F_RULE_PTR: v[3:0] = rp;
      default: v = '0;
    endcase
    return v;
  endfunction

  // whether a field carries meaning for this packet
  function automatic logic fld_ok(ica_pkg::ica_hdr_s h, int i);
    logic ok;
    ok = 1'b1;
    case (i)
      ica_pkg::F_OUT_VID, ica_pkg::F_OUT_TT, ica_pkg::F_OUT_PCP,
      ica_pkg::F_OUT_DEI: ok = (h.vlan_cnt != 2'h0);
      ica_pkg::F_IN_TT, ica_pkg::F_IN_VID, ica_pkg::F_IN_PCP,
      ica_pkg::F_IN_DEI: ok = (h.vlan_cnt >= 2'h2);
      ica_pkg::F_L4_SPORT, ica_pkg::F_L4_DPORT: begin
        ok = is_ip(h) && (h.l4_proto == ica_pkg::PROTO_UDP ||
                          h.l4_proto == ica_pkg::PROTO_TCP); // RULE21
      end
      ica_pkg::F_L4_PROTO: ok = is_ip(h);
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction

  // pack up to six fields above one valid bit per field
  function automatic logic [221:0] build_key(ica_pkg::ica_hdr_s h, logic [18:0] bm,
                                             logic [3:0] rp);
    logic [221:0] k;
    logic [47:0] v;
    logic ok;
    int n;
    int pos;
    k = '0; // RULE22
    n = 0;
    for (int i = 0; i < ica_pkg::FLD_N; i++) begin
      if (bm[i] && n < ica_pkg::FLD_MAX) begin
        n++;
      end
    end
    pos = n;
    n = 0;
    for (int i = 0; i < ica_pkg::FLD_N; i++) begin
      if (bm[i] && n < ica_pkg::FLD_MAX) begin // RULE14 RULE15
        ok = fld_ok(h, i);
        v = ok ? fld(h, i, rp) : 48'h0;
        k = k | ({174'h0, v} << pos);
        k[n] = ok;
        pos += ica_pkg::FLD_W[i];
        n++;
      end
    end
    return k;
  endfunction

  // d-left way index: fold the key, each way rotating on every fourth step at its own offset
  function automatic logic [1:0] hidx(logic [221:0] k, int w);
    logic [1:0] x;
    x = 2'h0;
    for (int i = 0; i < ica_pkg::KEY_W / 2; i++) begin
      if ((i % ica_pkg::WAY_N) == w) begin
        x = {x[0], x[1]} ^ k[2*i +: 2];
      end else begin
        x = x ^ k[2*i +: 2];
      end
    end
    return x;
  endfunction

  // per-port engine setup, cleared by reset
  logic [3:0] acl_en_q [ica_pkg::PORT_N];
  logic [3:0][3:0] rule_idx_q [ica_pkg::PORT_N];
  logic [2:0] pbits_q [ica_pkg::PORT_N];

  // hash ways and tcam, held in flops
  logic [221:0] hkey_q [ica_pkg::ENG_N][ica_pkg::WAY_N][ica_pkg::HDEP];
  ica_pkg::ica_act_s hact_q [ica_pkg::ENG_N][ica_pkg::WAY_N][ica_pkg::HDEP];
  logic hvld_q [ica_pkg::ENG_N][ica_pkg::WAY_N][ica_pkg::HDEP];
  logic [221:0] tkey_q [ica_pkg::ENG_N][ica_pkg::TCAM_N];
  logic [221:0] tmsk_q [ica_pkg::ENG_N][ica_pkg::TCAM_N];
  ica_pkg::ica_act_s tact_q [ica_pkg::ENG_N][ica_pkg::TCAM_N];
  logic tvld_q [ica_pkg::ENG_N][ica_pkg::TCAM_N];

  // lookup results for the header in flight
  ica_pkg::ica_act_s da_act;
  ica_pkg::ica_act_s sa_act;
  ica_pkg::ica_act_s rmc_act;
  ica_pkg::ica_act_s acl_act;
  ica_pkg::ica_act_s fin_d;
  logic [221:0] eng_key [ica_pkg::ENG_N];
  logic [3:0] eng_hit;
  logic [3:0] rule_ptr0;
  logic pre_hit;
  logic [10:0] pre_key;
  logic rmc_hit;

  logic res_valid_q;
  ica_pkg::ica_act_s res_q;
  logic [3:0] hit_q;
  logic [3:0] ptr0_q;

  // port table writes; every engine starts disabled on every port
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      for (int p = 0; p < ica_pkg::PORT_N; p++) begin
        acl_en_q[p] <= ica_pkg::ACL_EN_RST; // RULE12
        rule_idx_q[p] <= '0;
        pbits_q[p] <= '0;
      end
    end else if (port_cfg_i.en) begin
      acl_en_q[port_cfg_i.port] <= port_cfg_i.acl_port_enable;
      rule_idx_q[port_cfg_i.port] <= port_cfg_i.acl_rule_index;
      pbits_q[port_cfg_i.port] <= port_cfg_i.prelookup_port_bits;
    end
  end

  // acl entry writes; only valid bits need a reset value
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      for (int e = 0; e < ica_pkg::ENG_N; e++) begin
        for (int t = 0; t < ica_pkg::TCAM_N; t++) begin
          tvld_q[e][t] <= 1'b0;
        end
        for (int w = 0; w < ica_pkg::WAY_N; w++) begin
          for (int d = 0; d < ica_pkg::HDEP; d++) begin
            hvld_q[e][w][d] <= 1'b0;
          end
        end
      end
    end else if (acl_wr_i.en && acl_wr_i.tcam) begin
      tvld_q[acl_wr_i.eng][acl_wr_i.idx] <= acl_wr_i.valid;
      tkey_q[acl_wr_i.eng][acl_wr_i.idx] <= acl_wr_i.key;
      tmsk_q[acl_wr_i.eng][acl_wr_i.idx] <= acl_wr_i.mask;
      tact_q[acl_wr_i.eng][acl_wr_i.idx] <= acl_wr_i.act;
    end else if (acl_wr_i.en) begin
      hvld_q[acl_wr_i.eng][acl_wr_i.way][acl_wr_i.idx] <= acl_wr_i.valid;
      hkey_q[acl_wr_i.eng][acl_wr_i.way][acl_wr_i.idx] <= acl_wr_i.key;
      hact_q[acl_wr_i.eng][acl_wr_i.way][acl_wr_i.idx] <= acl_wr_i.act;
    end
  end

  // l2 checks: two range scans and reserved multicast
  always_comb begin
    da_act = '0;
    sa_act = '0;
    // ascending scan, so the highest matching entry sets the queue
    for (int r = 0; r < ica_pkg::RANGE_N; r++) begin // RULE1
      if (rhit(da_range_i[r], hdr_i.mac_da)) begin
        da_act = merge(da_act, da_range_i[r].act); // RULE2 RULE3 RULE5
      end
      if (rhit(sa_range_i[r], hdr_i.mac_sa)) begin
        sa_act = merge(sa_act, sa_range_i[r].act); // RULE2 RULE3 RULE5
      end
    end
    rmc_hit = (hdr_i.mac_da[47:8] == rmc_base_i) && rmc_port_en_i[hdr_i.src_port]; // RULE7
    rmc_act = '0;
    rmc_act.drop = rmc_hit && rmc_drop_i[hdr_i.mac_da[7:0]]; // RULE8
    rmc_act.redirect_to_host = rmc_hit && rmc_redirect_i[hdr_i.mac_da[7:0]];
  end

  // engine 0 pre-lookup; lowest matching entry wins
  always_comb begin
    pre_key = {pbits_q[hdr_i.src_port], hdr_i.vlan_cnt, hdr_i.avtp,
               l3_code(hdr_i), l4_code(hdr_i)}; // RULE17
    pre_hit = 1'b0;
    rule_ptr0 = rule_idx_q[hdr_i.src_port][0];
    for (int p = ica_pkg::PRE_N - 1; p >= 0; p--) begin
      if (pre_tbl_i[p].valid && ((pre_key ^ pre_tbl_i[p].key) & pre_tbl_i[p].mask) == '0) begin
        pre_hit = 1'b1;
        rule_ptr0 = pre_tbl_i[p].rule; // RULE16
      end
    end
  end

  // four engines in parallel: build key, probe hash ways then tcam
  always_comb begin
    logic [221:0] mk;
    logic [3:0] ptr;
    logic [1:0] ix;
    logic hit;
    ica_pkg::ica_act_s ea;
    mk = '0;
    ptr = '0;
    ix = '0;
    hit = 1'b0;
    ea = '0;
    acl_act = '0;
    eng_hit = '0;
    for (int e = 0; e < ica_pkg::ENG_N; e++) begin // RULE11
      ptr = (e == 0) ? rule_ptr0 : rule_idx_q[hdr_i.src_port][e]; // RULE13
      eng_key[e] = build_key(hdr_i, key_field_bitmap_i[e][ptr], ptr);
      mk = eng_key[e] & hash_mask_i[e]; // RULE10
      hit = 1'b0;
      ea = '0;
      for (int w = 0; w < ica_pkg::WAY_N; w++) begin // RULE9
        ix = hidx(mk, w);
        if (hvld_q[e][w][ix] && hkey_q[e][w][ix] == mk) begin
          hit = 1'b1;
          ea = hact_q[e][w][ix];
        end
      end
      // the tcam settles collisions, so its hit outranks the hash
      for (int t = ica_pkg::TCAM_N - 1; t >= 0; t--) begin
        if (tvld_q[e][t] && ((eng_key[e] ^ tkey_q[e][t]) & tmsk_q[e][t]) == '0) begin
          hit = 1'b1;
          ea = tact_q[e][t];
        end
      end
      if (acl_en_q[hdr_i.src_port][e] && hit) begin // RULE12
        eng_hit[e] = 1'b1;
        acl_act = merge(acl_act, ea);
      end
    end
  end

  // final merge: redirect beats drop, a discarded source beats both
  always_comb begin
    fin_d = merge(merge(merge(da_act, sa_act), rmc_act), acl_act);
    if (fin_d.redirect_to_host) begin
      fin_d.drop = 1'b0; // RULE4 RULE23
    end
    if (hdr_i.source_addr_discard) begin
      fin_d.drop = 1'b1; // RULE6
      fin_d.redirect_to_host = 1'b0;
    end
  end

  // result valid follows the header by one cycle
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      res_valid_q <= 1'b0;
    end else begin
      res_valid_q <= hdr_valid_i;
    end
  end

  // result data holds until the next header
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      res_q <= '0;
      hit_q <= '0;
      ptr0_q <= '0;
    end else if (hdr_valid_i) begin
      res_q <= fin_d;
      hit_q <= eng_hit;
      ptr0_q <= rule_ptr0;
    end
  end

  assign res_valid_o = res_valid_q;
  assign res_o = res_q;
  assign acl_hit_o = hit_q;
  assign rule_ptr0_o = ptr0_q;

  // checks
  a_res_latency: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    hdr_valid_i |=> res_valid_o) else $error("result missing after header");
  a_res_spurious: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !hdr_valid_i |=> !res_valid_o) else $error("result without header");
  a_redir_over_drop: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE4
    res_valid_o && res_o.redirect_to_host |-> !res_o.drop) else $error("redirect and drop");
  a_sa_discard: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE6
    hdr_valid_i && hdr_i.source_addr_discard |=> res_o.drop && !res_o.redirect_to_host)
    else $error("discarded source not dropped");
  a_range_drop: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE3
    hdr_valid_i && da_act.drop |=> res_o.drop || res_o.redirect_to_host)
    else $error("range drop lost");
  a_rmc_action: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE7
    hdr_valid_i && rmc_act.redirect_to_host && !hdr_i.source_addr_discard
    |=> res_o.redirect_to_host) else $error("reserved multicast redirect lost");
  a_acl_gate: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE12
    hdr_valid_i && acl_en_q[hdr_i.src_port] == 4'h0 |=> acl_hit_o == 4'h0)
    else $error("disabled engine hit");
  a_reset_off: assert property (@(posedge core_clk_i) // RULE12
    $past(sys_rst_i) && !sys_rst_i |-> acl_en_q[0] == 4'h0 && acl_en_q[63] == 4'h0)
    else $error("engine enabled after reset");
  a_pre_ptr: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE16
    hdr_valid_i && !pre_hit |=> rule_ptr0_o == $past(rule_idx_q[hdr_i.src_port][0]))
    else $error("port rule index not used");
  a_l3_code: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE18
    hdr_i.is_ipv6 && !hdr_i.is_ipv4 |-> pre_key[4:3] == ica_pkg::L3_IPV6)
    else $error("l3 code wrong");
  a_l4_code: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE19
    (hdr_i.is_ipv4 || hdr_i.is_ipv6) && hdr_i.l4_proto == ica_pkg::PROTO_TCP
    |-> pre_key[2:0] == ica_pkg::L4_TCP)
    else $error("l4 code wrong");
  c_redirect: cover property (@(posedge core_clk_i) res_valid_o && res_o.redirect_to_host);
  c_drop: cover property (@(posedge core_clk_i) res_valid_o && res_o.drop);
  c_acl_all: cover property (@(posedge core_clk_i) res_valid_o && acl_hit_o == 4'hF);
  c_pre_hit: cover property (@(posedge core_clk_i) hdr_valid_i && pre_hit);

endmodule

// >>> bench/ica_parser_model.sv
`timescale 1ns/1ns
module ica_parser_model (
  // clock
  input wire logic core_clk_i,
  // parsed header towards the classifier
  output logic hdr_valid_o,
  output ica_pkg::ica_hdr_s hdr_o
);
  // idle header lines start at zero, then show the inverse of the last header so a stale value never looks valid
  initial begin
    hdr_valid_o = 1'b0;
    hdr_o = '0;
  end

  // one header, one-cycle pulse, launched just after an edge
  task automatic send(input ica_pkg::ica_hdr_s h);
    @(posedge core_clk_i);
    hdr_valid_o <= 1'b1;
    hdr_o <= h;
    @(posedge core_clk_i);
    hdr_valid_o <= 1'b0;
    hdr_o <= ~h;
  endtask
endmodule

// >>> bench/ica_classifier_bench.sv
`timescale 1ns/1ns
module ica_classifier_bench;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hdr_valid;
  ica_pkg::ica_hdr_s hdr;
  ica_pkg::ica_hdr_s h;
  ica_pkg::ica_range_s da_rng [ica_pkg::RANGE_N];
  ica_pkg::ica_range_s sa_rng [ica_pkg::RANGE_N];
  logic [39:0] rmc_base = 40'h0180C20000;
  logic [255:0] rmc_drop = 256'h0;
  logic [255:0] rmc_redir = 256'h0;
  logic [63:0] rmc_port_en = 64'h0;
  ica_pkg::ica_port_cfg_s port_cfg = '0;
  ica_pkg::ica_acl_wr_s acl_wr = '0;
  logic [18:0] bitmap [ica_pkg::ENG_N][ica_pkg::RULE_N];
  logic [221:0] hmask [ica_pkg::ENG_N];
  ica_pkg::ica_pre_s pre_tbl [ica_pkg::PRE_N];
  logic res_valid;
  ica_pkg::ica_act_s res;
  logic [3:0] acl_hit;
  logic [3:0] rule_ptr0;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  ica_parser_model pm (.core_clk_i(core_clk_i), .hdr_valid_o(hdr_valid), .hdr_o(hdr));

  ica_classifier dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .hdr_valid_i(hdr_valid), .hdr_i(hdr),
    .da_range_i(da_rng), .sa_range_i(sa_rng), .rmc_base_i(rmc_base), .rmc_drop_i(rmc_drop),
    .rmc_redirect_i(rmc_redir), .rmc_port_en_i(rmc_port_en), .port_cfg_i(port_cfg),
    .acl_wr_i(acl_wr), .key_field_bitmap_i(bitmap), .hash_mask_i(hmask), .pre_tbl_i(pre_tbl),
    .res_valid_o(res_valid), .res_o(res), .acl_hit_o(acl_hit), .rule_ptr0_o(rule_ptr0)
  );

  // 125 MHz
  always #4 core_clk_i = ~core_clk_i;

  // hang guard, the whole run needs well under a hundred cycles
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one header from port 5; result is looked at in the single valid cycle
  task automatic pkt(input logic [47:0] da, input logic [47:0] sa, input logic disc,
                     input logic [5:0] exp);
    h = '0;
    h.mac_da = da;
    h.mac_sa = sa;
    h.src_port = 6'h05;
    h.source_addr_discard = disc;
    pm.send(h);
    #1;
    chk(64'(res_valid), 64'h1);
    chk(64'(res), 64'(exp));
  endtask

  // overlapping destination ranges: drop, redirect and queue merging
  task automatic t_da_range;
    @(posedge core_clk_i);
    da_rng[0] <= '{1'b1, 48'h100, 48'h1FF, 6'h0B};
    da_rng[2] <= '{1'b1, 48'h100, 48'h18F, 6'h29};
    da_rng[5] <= '{1'b1, 48'h180, 48'h1FF, 6'h1E};
    pkt(48'h185, 48'h300, 1'b0, 6'h1E);
    pkt(48'h105, 48'h300, 1'b0, 6'h29);
    pkt(48'h1FF, 48'h300, 1'b0, 6'h1E);
    pkt(48'h200, 48'h300, 1'b0, 6'h00);
  endtask

  // source range redirect, overruled by the source discard flag
  task automatic t_sa_discard;
    @(posedge core_clk_i);
    sa_rng[7] <= '{1'b1, 48'h0, 48'hFF, 6'h10};
    pkt(48'h0, 48'h10, 1'b0, 6'h10);
    pkt(48'h0, 48'h10, 1'b1, 6'h20);
  endtask

  // reserved multicast indexed by the low address byte, gated per port
  task automatic t_rmc;
    @(posedge core_clk_i);
    rmc_redir[8'h0E] <= 1'b1;
    rmc_drop[8'h07] <= 1'b1;
    rmc_port_en[5] <= 1'b1;
    pkt(48'h0180C200000E, 48'h300, 1'b0, 6'h10);
    pkt(48'h0180C2000007, 48'h300, 1'b0, 6'h20);
    pkt(48'h0180C3000007, 48'h300, 1'b0, 6'h00);
    @(posedge core_clk_i);
    rmc_port_en[5] <= 1'b0;
    pkt(48'h0180C2000007, 48'h300, 1'b0, 6'h00);
  endtask

  // wildcard tcam entry in engine 0, port enable, rule pointer and pre-lookup
  task automatic t_acl;
    @(posedge core_clk_i);
    acl_wr <= '{1'b1, 2'h0, 1'b1, 2'h0, 2'h0, 1'b1, 222'h0, 222'h0, 6'h20};
    @(posedge core_clk_i);
    acl_wr.en <= 1'b0;
    pkt(48'h0, 48'h300, 1'b0, 6'h00);
    chk(64'(acl_hit), 64'h0);
    port_cfg <= '{1'b1, 6'h05, 4'h1, 16'h0007, 3'h0};
    @(posedge core_clk_i);
    port_cfg.en <= 1'b0;
    pkt(48'h0, 48'h300, 1'b0, 6'h20);
    chk(64'(acl_hit), 64'h1);
    chk(64'(rule_ptr0), 64'h7);
    pre_tbl[1] <= '{1'b1, 11'h0, 11'h0, 4'h9};
    pkt(48'h0, 48'h300, 1'b0, 6'h20);
    chk(64'(rule_ptr0), 64'h9);
  endtask

  // engine 1 hash entry keyed on the source address, placed in every way and slot
  // so the hit does not depend on the hash index; engine 0 still drops
  task automatic t_hash;
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk_i);
      acl_wr <= '{1'b1, 2'h1, 1'b0, 2'(i / 4), 2'(i % 4), 1'b1, 222'h601, 222'h0, 6'h10};
    end
    @(posedge core_clk_i);
    acl_wr.en <= 1'b0;
    port_cfg <= '{1'b1, 6'h05, 4'h3, 16'h0007, 3'h0};
    @(posedge core_clk_i);
    port_cfg.en <= 1'b0;
    pkt(48'h0, 48'h300, 1'b0, 6'h10);
    chk(64'(acl_hit), 64'h3);
    pkt(48'h0, 48'h301, 1'b0, 6'h20);
    chk(64'(acl_hit), 64'h1);
    // shared mask hides the low source address bit
    @(posedge core_clk_i);
    hmask[1][1] <= 1'b0;
    pkt(48'h0, 48'h301, 1'b0, 6'h10);
    chk(64'(acl_hit), 64'h3);
    // exact pre-lookup entry for ipv6 tcp, lower index than the wildcard
    pre_tbl[0] <= '{1'b1, 11'h00B, 11'h7FF, 4'hC};
    h = '0;
    h.is_ipv6 = 1'b1;
    h.l4_proto = ica_pkg::PROTO_TCP;
    h.src_port = 6'h05;
    pm.send(h);
    #1;
    chk(64'(rule_ptr0), 64'hC);
  endtask

  // main sequence: reset for five cycles, then the scenarios
  initial begin
    for (int i = 0; i < ica_pkg::RANGE_N; i++) begin
      da_rng[i] = '0;
      sa_rng[i] = '0;
      pre_tbl[i] = '0;
    end
    for (int e = 0; e < ica_pkg::ENG_N; e++) begin
      hmask[e] = '1;
      for (int r = 0; r < ica_pkg::RULE_N; r++) begin
        bitmap[e][r] = 19'h04000;
      end
    end
    bitmap[1][0] = 19'h00002;
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk(64'({res_valid, res, acl_hit, rule_ptr0}), 64'h0);
    t_da_range();
    t_sa_discard();
    t_rmc();
    t_acl();
    t_hash();
    print_verdict();
  end
endmodule
